// file: design/wpt_pin_filter.sv
/*
  wpt_pin_filter: synchronises and debounces the timer input pin, emits edges.
  assumes the pin is asynchronous to clk_i; reset is synchronous active low.
*/
`timescale 1ns/1ps
`default_nettype none
module wpt_pin_filter (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  wpt_pin_if.src pin
);
  logic sync_a;
  logic sync_b;
  logic [wpt_pkg::FILT_W-1:0] run_cnt;
  logic level;
  logic level_d;
  wire differs = sync_b != level;
  wire settle = differs && (run_cnt == wpt_pkg::FILT_THRESH);

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  // a new level must persist 9 clocks: kills <=4-clock glitches, 12-clock pulses survive
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      run_cnt <= '0;
      level <= 1'b0;
      level_d <= 1'b0;
    end
    else
    begin
      level_d <= level;
      if (!differs)
        run_cnt <= '0;
      else if (settle)
      begin
        run_cnt <= '0;
        level <= sync_b;
      end
      else
        run_cnt <= run_cnt + 4'h1;
    end
  end

  assign pin.level = level;
  assign pin.rise = level && !level_d;
  assign pin.fall = !level && level_d;
endmodule
`default_nettype wire

// file: design/wpt_pin_if.sv
/*
  wpt_pin_if: carries the filtered timer input level and its edge pulses.
  assumes producer and consumer share clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface wpt_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// file: design/wpt_pkg.sv
/*
  wpt_pkg: constants and types for the window / pulse-width timer.
  assumes a single 100 MHz clock domain; no bus, control bits are plain ports.
*/
`default_nettype none
package wpt_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] START_RISE = 2'h2;
  localparam logic [1:0] START_FALL = 2'h3;
  localparam logic [1:0] START_CMD = 2'h1;
  localparam logic MODE_WINDOW = 1'h0;
  localparam logic MODE_PWM = 1'h1;
  localparam logic CAP_DOUBLE = 1'h0;
  localparam logic CAP_SINGLE = 1'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  // pin noise filter: reject <= 4 clocks, always pass >= 12 clocks
  localparam int unsigned FILT_REJECT_CYC = 4;
  localparam int unsigned FILT_PASS_CYC = 12;
  localparam int unsigned FILT_W = 4;
  localparam logic [FILT_W-1:0] FILT_THRESH = 4'h8;
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned DIV_W = 12;
  // source clock divide exponents per select code
  localparam logic [3:0] DIV_EXP_00 = 4'hb;
  localparam logic [3:0] DIV_EXP_01 = 4'h7;
  localparam logic [3:0] DIV_EXP_10 = 4'h3;
  localparam logic [3:0] DIV_EXP_11 = 4'h0;
  typedef enum logic [2:0] {
    WPT_IDLE = 3'h1,
    WPT_WAIT = 3'h2,
    WPT_RUN = 3'h4
  } wpt_state_t;
endpackage
`default_nettype wire

// file: design/wpt_timer.sv
/*
  wpt_timer: window-gated counting and pulse-width / period capture timer.
  assumes control fields only change while start_edge_select_i is stopped.
*/
// Operation
// - window mode counts source ticks while window open
// - window polarity selects high or low counting
// - window compare match pulses irq, clears counter
// - pulse mode starts counting on trigger edge
// - selects trigger edge and single/double capture
// - opposite edge captures counter and pulses irq
// - single-edge: load one, wait for next trigger
// - single-edge counter holds one until next edge
// - double-edge: trigger edge captures, clears, continues
// - input filter rejects short pulses
// - stop state forces start select to stopped
`timescale 1ns/1ps
`default_nettype none
module wpt_timer #(
  parameter int unsigned CNT_W = wpt_pkg::CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic timer_input_pin_i,
  input wire logic [1:0] start_edge_select_i,
  input wire logic mode_i,
  input wire logic window_neg_i,
  input wire logic capture_edge_mode_i,
  input wire logic [1:0] source_clock_select_i,
  input wire logic prescaler_divide_select_i,
  input wire logic stop_enter_i,
  input wire logic [CNT_W-1:0] period_compare_reg_i,
  output logic [CNT_W-1:0] capture_reg_o,
  output logic [CNT_W-1:0] count_o,
  output logic [1:0] start_edge_select_o,
  output logic running_o,
  output logic timer_irq_o
);
  wpt_pin_if pin ();
  wpt_pin_filter u_filter (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(timer_input_pin_i),
    .pin(pin)
  );

  logic [1:0] start_sel;
  logic [1:0] sel_seen;
  logic [wpt_pkg::DIV_W-1:0] div_cnt;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] cap;
  logic irq;
  logic next_irq;
  logic do_cap;
  logic running;
  wpt_pkg::wpt_state_t state;
  wpt_pkg::wpt_state_t next_state;

  function automatic logic [3:0] div_exp(input logic [1:0] sel, input logic dv);
    logic [3:0] e;
    e = 4'h0;
    unique case (sel)
      2'h0: e = wpt_pkg::DIV_EXP_00;
      2'h1: e = wpt_pkg::DIV_EXP_01;
      2'h2: e = wpt_pkg::DIV_EXP_10;
      2'h3: e = wpt_pkg::DIV_EXP_11;
    endcase
    if (dv && sel != 2'h3)
      e = e + 4'h1;
    return e;
  endfunction

  // counter step, shared by window and capture counting
  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // a change on the select port counts as a software write of the field
  wire sel_write = start_edge_select_i != sel_seen;

  // stop entry clears the image and it stays clear until software writes
  // the field again; a stale start code on the port must not restart it
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      start_sel <= wpt_pkg::START_STOP;
      sel_seen <= wpt_pkg::START_STOP;
    end
    else
    begin
      sel_seen <= start_edge_select_i;
      if (stop_enter_i)
        start_sel <= wpt_pkg::START_STOP;
      else if (sel_write)
        start_sel <= start_edge_select_i;
    end
  end

  wire stopped = start_sel == wpt_pkg::START_STOP;
  wire [3:0] exp_sel = div_exp(source_clock_select_i, prescaler_divide_select_i);
  wire [wpt_pkg::DIV_W:0] div_mask = ({{wpt_pkg::DIV_W{1'b0}}, 1'b1} << exp_sel) - 1'b1;
  wire tick = stopped ? 1'b0 :
    ((div_cnt & div_mask[wpt_pkg::DIV_W-1:0]) == '0);

  // divider restarts on every start so the first tick lands on a known clock
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || stopped)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 12'h001;
  end

  // trigger edge per start select; opposite edge is the other one
  wire trig_fall = start_sel == wpt_pkg::START_FALL;
  wire trig_edge = trig_fall ? pin.fall : pin.rise;
  wire opp_edge = trig_fall ? pin.rise : pin.fall;
  wire win_open = window_neg_i ? !pin.level : pin.level;
  wire match = cnt == period_compare_reg_i;
  wire single = capture_edge_mode_i == wpt_pkg::CAP_SINGLE;

  always_comb
  begin
    next_cnt = cnt;
    next_state = state;
    next_irq = 1'b0;
    do_cap = 1'b0;
    if (stopped)
    begin
      next_state = wpt_pkg::WPT_IDLE;
      next_cnt = wpt_pkg::CNT_ZERO;
    end
    else if (mode_i == wpt_pkg::MODE_WINDOW)
    begin
      next_state = wpt_pkg::WPT_RUN;
      // compare runs every clock, so software keeps the compare value above 0
      if (match)
      begin
        next_irq = 1'b1;
        next_cnt = wpt_pkg::CNT_ZERO;
      end
      else if (tick && win_open)
        next_cnt = inc(cnt);
    end
    else
    begin
      unique case (state)
        wpt_pkg::WPT_IDLE, wpt_pkg::WPT_WAIT:
        begin
          if (trig_edge)
          begin
            next_state = wpt_pkg::WPT_RUN;
            // counter keeps 0 from idle or the held 1 from wait
          end
          else if (state == wpt_pkg::WPT_WAIT)
            next_cnt = wpt_pkg::CNT_ONE;
        end
        wpt_pkg::WPT_RUN:
        begin
          if (opp_edge && single)
          begin
            do_cap = 1'b1;
            next_irq = 1'b1;
            next_cnt = wpt_pkg::CNT_ONE;
            next_state = wpt_pkg::WPT_WAIT;
          end
          else if (opp_edge)
          begin
            do_cap = 1'b1;
            next_irq = 1'b1;
            if (tick)
              next_cnt = inc(cnt);
          end
          else if (trig_edge && !single)
          begin
            do_cap = 1'b1;
            next_irq = 1'b1;
            next_cnt = wpt_pkg::CNT_ZERO;
          end
          else if (tick)
            next_cnt = inc(cnt);
        end
        default:
          next_state = wpt_pkg::WPT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= wpt_pkg::WPT_IDLE;
      cnt <= wpt_pkg::CNT_RST;
      cap <= wpt_pkg::CNT_RST;
      irq <= 1'b0;
      running <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // registered so the status port leaves a flip-flop like the others
      running <= next_state == wpt_pkg::WPT_RUN;
      cnt <= next_cnt;
      irq <= next_irq;
      if (do_cap)
        cap <= cnt;
    end
  end

  assign capture_reg_o = cap;
  assign count_o = cnt;
  assign start_edge_select_o = start_sel;
  assign running_o = running;
  assign timer_irq_o = irq;
endmodule
`default_nettype wire

// file: testbench/window_and_pulse_width_timer_tb.sv
/* window_and_pulse_width_timer_tb: directed tests of window and capture modes.
   assumes a tick every clock (select 11, prescaler 0) and compare value 5. */
`timescale 1ns/1ps
`default_nettype none
module window_and_pulse_width_timer_tb;
  logic clk_i = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] ssel = 2'h0;
  logic mode = 1'b0;
  logic neg = 1'b0;
  logic cem = 1'b0;
  logic stop = 1'b0;
  logic pin;
  logic [15:0] cap;
  logic [15:0] cnt;
  logic [1:0] ssel_o;
  logic run;
  logic irq;
  int num_errors = 0;
  int checks = 0;
  int irqs = 0;
  logic [15:0] caps[$];
  initial forever #5 clk_i = ~clk_i;
  wpt_pulse_src src (.clk_i(clk_i), .pin_o(pin));
  wpt_timer dut (.clk_i(clk_i), .rst_b_i(rst_b), .timer_input_pin_i(pin),
    .start_edge_select_i(ssel), .mode_i(mode), .window_neg_i(neg), .capture_edge_mode_i(cem),
    .source_clock_select_i(2'h3), .prescaler_divide_select_i(1'b0), .stop_enter_i(stop),
    .period_compare_reg_i(16'h0005), .capture_reg_o(cap), .count_o(cnt),
    .start_edge_select_o(ssel_o), .running_o(run), .timer_irq_o(irq));
  always @(posedge clk_i)
    if (irq === 1'b1)
    begin
      irqs++;
      caps.push_back(cap);
    end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  // reconfigure only after a stop, as a user must
  task automatic go(input logic m, input logic c, input logic n, input logic [1:0] s);
    @(posedge clk_i);
    #1 ssel = wpt_pkg::START_STOP;
    repeat (3) @(posedge clk_i);
    #1 mode = m;
    cem = c;
    neg = n;
    @(posedge clk_i);
    #1 ssel = s;
    irqs = 0;
    caps = {};
  endtask
  task automatic test_window;
    for (int p = 0; p < 2; p++)
    begin
      go(wpt_pkg::MODE_WINDOW, 1'b0, 1'(p), wpt_pkg::START_CMD);
      src.drive(1'(p), 40);
      chk("win shut", 16'h0, 16'(irqs));
      src.drive(~1'(p), 60);
      chk("win open", 16'h1, {15'h0, irqs > 0});
    end
    $display("end window");
  endtask
  task automatic test_single;
    for (int f = 0; f < 2; f++)
    begin
      src.drive(1'(f), 30);
      go(wpt_pkg::MODE_PWM, wpt_pkg::CAP_SINGLE, 1'b0,
        f ? wpt_pkg::START_FALL : wpt_pkg::START_RISE);
      src.drive(~1'(f), 4);
      src.drive(1'(f), 30);
      chk("glitch", 16'h0, 16'(irqs));
      repeat (2)
      begin
        src.drive(~1'(f), 20);
        src.drive(1'(f), 30);
      end
      chk("single irqs", 16'h2, 16'(irqs));
      chk("single hold", caps[0] + 16'h1, caps[1]);
    end
    $display("end single");
  endtask
  task automatic test_double;
    src.drive(1'b0, 30);
    go(wpt_pkg::MODE_PWM, wpt_pkg::CAP_DOUBLE, 1'b0, wpt_pkg::START_RISE);
    repeat (3)
    begin
      src.drive(1'b1, 20);
      src.drive(1'b0, 17);
    end
    src.drive(1'b1, 20);
    chk("double irqs", 16'h6, 16'(irqs));
    chk("double low", 16'h11, caps[3] - caps[2]);
    chk("double clear", caps[2], caps[4]);
    $display("end double");
  endtask
  task automatic test_stop;
    go(wpt_pkg::MODE_PWM, wpt_pkg::CAP_DOUBLE, 1'b0, wpt_pkg::START_RISE);
    src.drive(1'b0, 20);
    src.drive(1'b1, 20);
    #1 chk("stop before", 16'h1, {15'h0, run});
    stop = 1'b1;
    @(posedge clk_i);
    #1 stop = 1'b0;
    @(posedge clk_i);
    #1 chk("stop sel", 16'h0, {14'h0, ssel_o});
    chk("stop run", 16'h0, {15'h0, run});
    chk("stop count", 16'h0, cnt);
    repeat (5) @(posedge clk_i);
    #1 chk("stop held", 16'h0, {14'h0, ssel_o});
    $display("end stop");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    #1 rst_b = 1'b1;
    test_window();
    test_single();
    test_double();
    test_stop();
    end_sim();
  end
  initial
  begin
    #40000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: testbench/wpt_pulse_src.sv
/* wpt_pulse_src: outside pulse source on the timer input pin.
   assumes clk_i is the timer clock; levels change 1 ns after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module wpt_pulse_src (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // whole-cycle phases, kept far longer than one source tick
  task automatic drive(input logic lvl, input int n);
    @(posedge clk_i);
    #1 pin_o = lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/wpt_timer_checker.sv
/* wpt_timer_checker: port-level assertions for wpt_timer.
   assumes one clk_i domain with sync active-low rst_b_i. */
`timescale 1ns/1ps
`default_nettype none
module wpt_timer_checker #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mode_i,
  input wire logic capture_edge_mode_i,
  input wire logic stop_enter_i,
  input wire logic [CNT_W-1:0] period_compare_reg_i,
  input wire logic [CNT_W-1:0] capture_reg_o,
  input wire logic [CNT_W-1:0] count_o,
  input wire logic [1:0] start_edge_select_o,
  input wire logic running_o,
  input wire logic timer_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic on = start_edge_select_o != 2'h0;
  wire logic pw = mode_i == wpt_pkg::MODE_PWM;
  property p_irq_pulse; timer_irq_o |=> !timer_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_irq_cause; timer_irq_o |-> $past(on); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq while stopped");
  property p_stop_force; stop_enter_i |=> !on; endproperty
  a_stop_force: assert property (p_stop_force) else $error("stop not forced");
  property p_stopped; !on [*3] |-> !timer_irq_o && count_o == '0 && !running_o; endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer active");
  property p_cap_irq; $changed(capture_reg_o) |-> timer_irq_o; endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture without irq");
  property p_win_match;
    on && !pw && count_o == period_compare_reg_i |=> timer_irq_o && count_o == '0;
  endproperty
  a_win_match: assert property (p_win_match) else $error("window match missed");
  property p_single_hold;
    on && pw && capture_edge_mode_i && timer_irq_o |-> count_o == 1 && !running_o;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single hold wrong");
  property p_double_run; on && pw && !capture_edge_mode_i && timer_irq_o |-> running_o; endproperty
  a_double_run: assert property (p_double_run) else $error("double stopped");
endmodule
bind wpt_timer wpt_timer_checker #(.CNT_W(CNT_W)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .mode_i(mode_i), .capture_edge_mode_i(capture_edge_mode_i), .stop_enter_i(stop_enter_i),
  .period_compare_reg_i(period_compare_reg_i), .capture_reg_o(capture_reg_o),
  .count_o(count_o), .start_edge_select_o(start_edge_select_o), .running_o(running_o),
  .timer_irq_o(timer_irq_o));
`default_nettype wire
